// *** pkg/drt_pkg.sv ***
/*
  Constants, types and register layout of the refresh interval timer.
  Assumes one clock (the external bus clock) and a simple word/byte
  register port driven by logic on that same clock.
*/
package drt_pkg;

  // ==========================================================
  // register select codes
  localparam logic [1:0] DRT_SEL_CSR   = 2'h0;
  localparam logic [1:0] DRT_SEL_CNT   = 2'h1;
  localparam logic [1:0] DRT_SEL_LIM   = 2'h2;
  localparam logic [1:0] DRT_SEL_TALLY = 2'h3;

  // ==========================================================
  // write keys
  localparam logic [7:0] DRT_KEY_BYTE  = 8'hA5;
  localparam logic [5:0] DRT_KEY_TALLY = 6'h29;

  // ==========================================================
  // control/status bit positions
  localparam int DRT_B_CMF  = 7;
  localparam int DRT_B_MATCH_IRQ_ENABLE = 6;
  localparam int DRT_B_CKSH = 5;
  localparam int DRT_B_CKSL = 3;
  localparam int DRT_B_OVF  = 2;
  localparam int DRT_B_OVERFLOW_IRQ_ENABLE = 1;
  localparam int DRT_B_TALLY_LIMIT_SELECT = 0;

  // ==========================================================
  // reset values and limits
  localparam logic [7:0]  DRT_CSR_RST   = 8'h00;
  localparam logic [7:0]  DRT_CNT_RST   = 8'h00;
  localparam logic [7:0]  DRT_LIM_RST   = 8'h00;
  localparam logic [9:0]  DRT_TALLY_RST = 10'h000;
  localparam logic [10:0] DRT_LIMIT_LO  = 11'h400;
  localparam logic [10:0] DRT_LIMIT_HI  = 11'h200;
  localparam int          DRT_PRE_W     = 12;

  // ==========================================================
  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        word;
    logic [1:0]  sel;
    logic [15:0] wdata;
  } drt_req_s;

endpackage

// *** core/drt_top.sv ***
/*
  Refresh interval timer: prescaler, interval counter, limit, refresh
  tally, control/status, keyed writes and 16-bit reads.
  Assumes all inputs come from logic on clk; arst_n is power-on reset.
*/
`timescale 1ns/1ps
module drt_top
  import drt_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // reset and power modes
  input  wire logic        manual_rst,
  input  wire logic        standby,
  // memory control register bits
  input  wire logic        refresh_enable_bit,
  input  wire logic        cbr_mode,
  // register port
  input  wire drt_req_s    req,
  output logic [15:0]      rdata,
  output logic             rvalid,
  // refresh and interrupt requests
  output logic             refresh_req,
  output logic             match_irq,
  output logic             overflow_irq
);

  // ==========================================================
  // state
  logic [7:0]           csr_r;
  logic [7:0]           cnt_r;
  logic [7:0]           lim_r;
  logic [9:0]           tally_r;
  logic [DRT_PRE_W-1:0] pre_r;
  logic                 tick;
  logic                 match;
  logic                 key_ok;
  logic                 tkey_ok;
  logic                 wr_csr;
  logic                 wr_cnt;
  logic                 wr_lim;
  logic                 wr_tally;
  logic [10:0]          tally_inc;
  logic [10:0]          tally_lim;
  logic                 ovf_hit;
  logic [2:0]           cks;

  // selected prescaler tap reaching its last count
  function automatic logic div_tick(input logic [2:0] sel,
                                    input logic [DRT_PRE_W-1:0] p);
    logic [DRT_PRE_W-1:0] m;
    m = '0;
    unique case (sel)
      3'h0: m = '0;
      3'h1: m = 12'h003;
      3'h2: m = 12'h00F;
      3'h3: m = 12'h03F;
      3'h4: m = 12'h0FF;
      3'h5: m = 12'h3FF;
      3'h6: m = 12'h7FF;
      3'h7: m = 12'hFFF;
    endcase
    return (sel != 3'h0) && ((p & m) == m);
  endfunction

  // ==========================================================
  // decode
  assign cks = csr_r[DRT_B_CKSH:DRT_B_CKSL];
  assign key_ok  = req.wdata[15:8] == DRT_KEY_BYTE;
  assign tkey_ok = req.wdata[15:10] == DRT_KEY_TALLY;
  assign wr_csr   = req.wr && req.word && key_ok && req.sel == DRT_SEL_CSR;
  assign wr_cnt   = req.wr && req.word && key_ok && req.sel == DRT_SEL_CNT;
  assign wr_lim   = req.wr && req.word && key_ok && req.sel == DRT_SEL_LIM;
  assign wr_tally = req.wr && req.word && tkey_ok
                    && req.sel == DRT_SEL_TALLY;

  assign tick  = !standby && div_tick(cks, pre_r);
  assign match = tick && (cnt_r == lim_r);

  assign tally_lim = csr_r[DRT_B_TALLY_LIMIT_SELECT] ? DRT_LIMIT_HI : DRT_LIMIT_LO;
  assign tally_inc = {1'b0, tally_r} + 11'h001;
  // overflow when the count reaches the limit
  assign ovf_hit   = match && (tally_inc >= tally_lim);

  // ==========================================================
  // prescaler
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_r <= '0;
    end else if (ce && !standby) begin
      pre_r <= pre_r + 12'h001;
    end
  end

  // ==========================================================
  // interval counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= DRT_CNT_RST;
    end else if (ce) begin
      if (wr_cnt) begin
        cnt_r <= req.wdata[7:0];
      end else if (match) begin
        cnt_r <= 8'h00;
      end else if (tick) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  // ==========================================================
  // interval limit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lim_r <= DRT_LIM_RST;
    end else if (ce && wr_lim) begin
      lim_r <= req.wdata[7:0];
    end
  end

  // ==========================================================
  // refresh tally
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tally_r <= DRT_TALLY_RST;
    end else if (ce) begin
      if (wr_tally) begin
        tally_r <= req.wdata[9:0];
      end else if (ovf_hit) begin
        tally_r <= 10'h000;
      end else if (match) begin
        tally_r <= tally_inc[9:0];
      end
    end
  end

  // ==========================================================
  // control/status
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      csr_r <= DRT_CSR_RST;
    end else if (ce) begin
      if (manual_rst) begin
        csr_r <= DRT_CSR_RST;
        csr_r[DRT_B_CKSH:DRT_B_CKSL] <= cks;
      end else begin
        if (wr_csr) begin
          csr_r[6:3] <= req.wdata[6:3];
          csr_r[1:0] <= req.wdata[1:0];
        end
        if (match) begin
          csr_r[DRT_B_CMF] <= 1'b1;
        end else if (wr_csr && !req.wdata[DRT_B_CMF]) begin
          csr_r[DRT_B_CMF] <= 1'b0;
        end
        if (ovf_hit) begin
          csr_r[DRT_B_OVF] <= 1'b1;
        end else if (wr_csr && !req.wdata[DRT_B_OVF]) begin
          csr_r[DRT_B_OVF] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // requests
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      refresh_req  <= 1'b0;
      match_irq    <= 1'b0;
      overflow_irq <= 1'b0;
    end else if (ce) begin
      // refresh on match in CBR mode with the refresh enable bit set
      refresh_req  <= match && refresh_enable_bit && cbr_mode;
      match_irq    <= csr_r[DRT_B_CMF] && csr_r[DRT_B_MATCH_IRQ_ENABLE];
      overflow_irq <= csr_r[DRT_B_OVF] && csr_r[DRT_B_OVERFLOW_IRQ_ENABLE];
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end else if (ce) begin
      rvalid <= req.rd;
      if (req.rd) begin
        unique case (req.sel)
          DRT_SEL_CSR:   rdata <= {8'h00, csr_r};
          DRT_SEL_CNT:   rdata <= {8'h00, cnt_r};
          DRT_SEL_LIM:   rdata <= {8'h00, lim_r};
          DRT_SEL_TALLY: rdata <= {6'h00, tally_r};
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  cnt_step_a: assert property (ce && tick && !match && !wr_cnt
    |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("interval counter did not advance");
  cnt_clear_a: assert property (ce && match && !wr_cnt && !manual_rst
    |=> cnt_r == 8'h00 && csr_r[DRT_B_CMF])
    else $error("match did not clear counter and set flag");
  refresh_go_a: assert property (ce && match && refresh_enable_bit
    && cbr_mode |=> refresh_req ##1 (!refresh_req || !$past(ce)))
    else $error("refresh request missing");
  tally_step_a: assert property (ce && match && !ovf_hit
    && !wr_tally |=> tally_r == $past(tally_r) + 10'h001)
    else $error("tally did not advance");
  tally_ovf_a: assert property (ce && ovf_hit && !wr_tally
    && !manual_rst |=> tally_r == 10'h000 && csr_r[DRT_B_OVF])
    else $error("overflow not flagged");
  byte_wr_a: assert property (ce && req.wr && !req.word
    |=> $stable(lim_r))
    else $error("byte write changed limit");
  flag_keep_a: assert property (ce && csr_r[DRT_B_CMF] && wr_csr
    && req.wdata[DRT_B_CMF] && !manual_rst |=> csr_r[DRT_B_CMF])
    else $error("writing one cleared match flag");
  bad_key_a: assert property (ce && req.wr && req.sel == DRT_SEL_LIM
    && !key_ok |=> $stable(lim_r))
    else $error("unkeyed write changed limit");
  irq_gate_a: assert property (ce ##1 match_irq
    |-> $past(csr_r[DRT_B_MATCH_IRQ_ENABLE]))
    else $error("match request without enable");
  read_zero_a: assert property (ce && req.rd && req.sel != DRT_SEL_TALLY
    |=> rdata[15:8] == 8'h00 && rvalid)
    else $error("undefined read bits not zero");

endmodule

// *** test/drt_mem_model.sv ***
/*
  Behavioural dynamic memory on the refresh side of the timer: it takes
  each refresh pulse as one refresh cycle and keeps a running count.
  Assumes refresh_req is a one-cycle pulse on clk.
*/
`timescale 1ns/1ps
module drt_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // refresh request from the timer
  input  wire logic        refresh_req,
  // refresh cycles carried out so far
  output logic [15:0]      refresh_count
);
  // ==========================================================
  // refresh cycle count
  // one pulse, one refresh
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      refresh_count <= 16'h0000;
    else if (refresh_req)
      refresh_count <= refresh_count + 16'h0001;
  end
endmodule

// *** test/dram_refresh_interval_timer_tb.sv ***
/*
  Self-checking bench for the refresh interval timer: keyed writes,
  16-bit reads, interval matches, refresh pulses, tally overflow, resets.
  Assumes drt_pkg and drt_top; the memory model counts refreshes.
*/
`timescale 1ns/1ps
module dram_refresh_interval_timer_tb
  import drt_pkg::*;
;
  logic        clk, arst_n, ce, manual_rst, standby, ren, cbr;
  drt_req_s    req;
  logic [15:0] rdata, v, m0, refresh_count;
  logic        rvalid, refresh_req, match_irq, overflow_irq;
  int          n_fail, check_count;

  drt_top uut (.clk(clk), .arst_n(arst_n), .ce(ce),
    .manual_rst(manual_rst), .standby(standby),
    .refresh_enable_bit(ren), .cbr_mode(cbr), .req(req),
    .rdata(rdata), .rvalid(rvalid), .refresh_req(refresh_req),
    .match_irq(match_irq), .overflow_irq(overflow_irq));
  drt_mem_model mem (.clk(clk), .arst_n(arst_n),
    .refresh_req(refresh_req), .refresh_count(refresh_count));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // verdict and comparisons
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ==========================================================
  // register port tasks
  task wr(logic [1:0] s, logic [15:0] d, logic w = 1'b1);
    @(posedge clk);
    req.wr <= 1'b1;
    req.word <= w;
    req.sel <= s;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task rd(logic [1:0] s, output logic [15:0] d);
    int i;
    @(posedge clk);
    req.rd <= 1'b1;
    req.sel <= s;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (rvalid !== 1'b1) begin
      n_fail++;
      $display("mismatch read answer expected 1 seen 0");
      report_and_stop();
    end
    d = rdata;
  endtask

  task rc(logic [1:0] s, logic [15:0] exp, string what);
    logic [15:0] d;
    rd(s, d);
    chk(what, exp, d);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    n_fail = 0;
    check_count = 0;
    arst_n = 1'b0;
    ce = 1'b1;
    manual_rst = 1'b0;
    standby = 1'b0;
    ren = 1'b1;
    cbr = 1'b1;
    req = '0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (int s = 0; s < 4; s++)
      rc(s[1:0], 16'h0000, "reset value");
    $display("test reset done");
    wr(DRT_SEL_LIM, 16'hA503);
    rc(DRT_SEL_LIM, 16'h0003, "limit");
    wr(DRT_SEL_LIM, 16'hA577, 1'b0);
    rc(DRT_SEL_LIM, 16'h0003, "limit byte write");
    wr(DRT_SEL_LIM, 16'h5A77);
    rc(DRT_SEL_LIM, 16'h0003, "limit bad key");
    wr(DRT_SEL_CNT, 16'hA555);
    rc(DRT_SEL_CNT, 16'h0055, "counter");
    wr(DRT_SEL_TALLY, 16'hA7FF);
    rc(DRT_SEL_TALLY, 16'h03FF, "tally");
    wr(DRT_SEL_TALLY, 16'hABFF);
    rc(DRT_SEL_TALLY, 16'h03FF, "tally bad key");
    $display("test keyed access done");
    wr(DRT_SEL_CNT, 16'hA500);
    wr(DRT_SEL_CSR, 16'hA548);
    repeat (20) @(posedge clk);
    #1 m0 = refresh_count;
    repeat (160) @(posedge clk);
    #1 chk("refreshes", 16'h000A, refresh_count - m0);
    for (int k = 1; k < 3; k++) begin
      @(posedge clk);
      ren <= k[0];
      cbr <= k[1];
      repeat (2) @(posedge clk);
      #1 m0 = refresh_count;
      repeat (64) @(posedge clk);
      #1 chk("gated refreshes", 16'h0000, refresh_count - m0);
    end
    @(posedge clk);
    ren <= 1'b1;
    cbr <= 1'b1;
    wr(DRT_SEL_CSR, 16'hA5C0);
    rc(DRT_SEL_CSR, 16'h00C0, "match flag kept");
    chk("match irq", 16'h0001, {15'h0000, match_irq});
    wr(DRT_SEL_CSR, 16'hA540);
    rc(DRT_SEL_CSR, 16'h0040, "match flag cleared");
    chk("match irq off", 16'h0000, {15'h0000, match_irq});
    $display("test interval match done");
    for (int k = 0; k < 2; k++) begin
      wr(DRT_SEL_CSR, 16'hA502);
      @(posedge clk);
      #1 chk("overflow irq off", 16'h0000, {15'h0000, overflow_irq});
      wr(DRT_SEL_TALLY, {6'b101001, k[0] ? 10'h1FF : 10'h3FF});
      m0 = refresh_count;
      wr(DRT_SEL_CSR, {8'hA5, 7'h05, k[0]});
      repeat (40) @(posedge clk);
      wr(DRT_SEL_CSR, {8'hA5, 7'h03, k[0]});
      rd(DRT_SEL_CSR, v);
      chk("overflow flag", {8'h00, 7'h03, k[0]}, v & 16'hFF7F);
      chk("overflow irq", 16'h0001, {15'h0000, overflow_irq});
      rd(DRT_SEL_TALLY, v);
      chk("tally wrap", refresh_count - m0 - 16'h0001, v);
    end
    $display("test tally overflow done");
    wr(DRT_SEL_CNT, 16'hA544);
    wr(DRT_SEL_TALLY, 16'hA555);
    @(posedge clk);
    standby <= 1'b1;
    wr(DRT_SEL_CSR, 16'hA508);
    repeat (40) @(posedge clk);
    rc(DRT_SEL_CNT, 16'h0044, "counter in standby");
    rc(DRT_SEL_TALLY, 16'h0155, "tally in standby");
    @(posedge clk);
    manual_rst <= 1'b1;
    @(posedge clk);
    manual_rst <= 1'b0;
    rc(DRT_SEL_CSR, 16'h0008, "csr after manual reset");
    rc(DRT_SEL_CNT, 16'h0044, "counter kept");
    rc(DRT_SEL_LIM, 16'h0003, "limit kept");
    rc(DRT_SEL_TALLY, 16'h0155, "tally kept");
    @(posedge clk);
    standby <= 1'b0;
    wr(DRT_SEL_CNT, 16'hA500);
    repeat (20) @(posedge clk);
    #1 m0 = refresh_count;
    repeat (160) @(posedge clk);
    #1 chk("refreshes kept", 16'h000A, refresh_count - m0);
    @(posedge clk);
    ce <= 1'b0;
    wr(DRT_SEL_LIM, 16'hA577);
    ce <= 1'b1;
    rc(DRT_SEL_LIM, 16'h0003, "limit frozen");
    $display("test manual reset done");
    wr(DRT_SEL_LIM, 16'hA500);
    wr(DRT_SEL_CNT, 16'hA500);
    for (int c = 2; c < 8; c++) begin
      wr(DRT_SEL_CSR, {8'hA5, 2'b00, c[2:0], 3'b000});
      repeat (2) @(posedge clk);
      #1 m0 = refresh_count;
      repeat ((c < 5) ? (32'h4 << (2 * c)) : (32'h400 << (c - 3)))
        @(posedge clk);
      #1 chk("divided refreshes", 16'h0004, refresh_count - m0);
    end
    $display("test clock select done");
    wr(DRT_SEL_LIM, 16'hA5C3);
    wr(DRT_SEL_CNT, 16'hA544);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (int s = 0; s < 4; s++)
      rc(s[1:0], 16'h0000, "power-on value");
    $display("test resets done");
    report_and_stop();
  end
endmodule
